// ---- design/ccsb_pkg.sv ----
/*
 * constants for the card-side clock supervision and bit-rate block:
 * core clock rate, card clock limits, wait counts, default bit period,
 * status words and file-characteristics bit positions.
 * assumes the core clock runs at 50 MHz and the terminal pins are
 * already synchronous to it.
 */
// Functional notes
// - both ends speak the half-duplex character protocol
// - terminal supplies clock, card runs 1-5 MHz; freq_err flags below 13/8 MHz, or 13/4 MHz with bit 2 set
// - fast-clock need flagged in characteristics bit 2
// - card operating during commands, idle otherwise, retains
// - card answers legacy power-down with normal completion; the code answers it only while idle
// - reset answer bit period is 372 card cycles
// - period stays 372 unless rate exchange succeeded
package ccsb_pkg;
	// core clock
	localparam int unsigned CORE_HZ = 50_000_000;
	// card clock limits in hertz
	localparam int unsigned CARD_MAX_HZ = 5_000_000;
	localparam int unsigned CARD_MIN_HZ = 1_000_000;
	localparam int unsigned CARD_FAST_MIN_HZ = 3_250_000; // 13/4 MHz
	localparam int unsigned CARD_SLOW_MIN_HZ = 1_625_000; // 13/8 MHz
	// shortest legal card period in core cycles, rounded up
	localparam int unsigned PER_MIN_CYC =
		(CORE_HZ + CARD_MAX_HZ - 1) / CARD_MAX_HZ;
	// longest legal periods in core cycles, rounded down
	localparam int unsigned PER_FAST_MAX_CYC = CORE_HZ / CARD_FAST_MIN_HZ;
	localparam int unsigned PER_SLOW_MAX_CYC = CORE_HZ / CARD_SLOW_MIN_HZ;
	// no edge for twice the slowest period means the clock is stopped
	localparam int unsigned STOP_DET_CYC = 2 * (CORE_HZ / CARD_MIN_HZ);
	// duty limits as fractions of five: 2/5 = 40 %, 3/5 = 60 %
	localparam int unsigned DUTY_LO_FIFTHS = 2;
	localparam int unsigned DUTY_HI_FIFTHS = 3;
	// widths
	localparam int unsigned PER_W = 8;
	localparam int unsigned CYC_W = 11;
	localparam int unsigned DIV_W = 12;
	// waits in card clock cycles
	localparam logic [CYC_W-1:0] STOP_WAIT_CYC = 11'd1860;
	localparam logic [CYC_W-1:0] START_WAIT_CYC = 11'd744;
	localparam logic [CYC_W-1:0] SLEEP_WAIT_CYC = 11'd744;
	// default bit period in card clock cycles
	localparam logic [DIV_W-1:0] ETU_DEFAULT = 12'd372;
	// normal completion status words
	localparam logic [7:0] SW_NORMAL_1 = 8'h90;
	localparam logic [7:0] SW_NORMAL_2 = 8'h00;
	// file characteristics byte 1 bit positions
	localparam int unsigned FC_STOP_OK_BIT = 0;
	localparam int unsigned FC_FAST_CLK_BIT = 2;
	// byte 1 of file characteristics after reset
	localparam logic [7:0] FC_RESET = 8'h00;
	// legacy power-down instruction code
	localparam logic [7:0] INS_POWER_DOWN = 8'hf0;
	// activity state
	typedef enum logic [1:0] {
		CCSB_IDLE,
		CCSB_OPERATING,
		CCSB_ANSWER
	} ccsb_state_t;
endpackage : ccsb_pkg

// ---- design/ccsb_etu_timer.sv ----
/*
 * bit-period timer: counts rising card clock edges and pulses once per
 * bit period; a restart pulse realigns it to a start bit edge.
 * assumes card_rise is a one-cycle pulse in the core clock domain.
 */
`timescale 1ns/1ps
module ccsb_etu_timer (
	// clock and reset
	input wire logic core_clk,
	input wire logic resetn,
	input wire logic clk_en,
	// card clock edge and control
	input wire logic card_rise,
	input wire logic restart,
	input wire logic [ccsb_pkg::DIV_W-1:0] divisor,
	// ticks
	output logic etu_tick,
	output logic half_tick
);
	logic [ccsb_pkg::DIV_W-1:0] cnt_r; // card edges within the bit
	logic [ccsb_pkg::DIV_W-1:0] cnt_nxt;
	logic tick_r;
	logic half_r;
	wire last = (cnt_r == divisor - 12'h001);
	wire mid = (cnt_r == (divisor >> 1));

	// counting card edges, not core cycles, scales the rate with the clock
	assign cnt_nxt = last ? '0 : cnt_r + 12'h001;
	assign etu_tick = tick_r;
	assign half_tick = half_r;

	// counter and tick flops
	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			cnt_r <= '0;
			tick_r <= 1'b0;
			half_r <= 1'b0;
		end else if (clk_en) begin
			tick_r <= 1'b0;
			half_r <= 1'b0;
			if (restart) begin
				cnt_r <= '0;
			end else if (card_rise) begin
				cnt_r <= cnt_nxt;
				tick_r <= last;
				half_r <= mid;
			end
		end
	end
endmodule : ccsb_etu_timer

// ---- design/ccsb_card_clk_ctrl.sv ----
/*
 * card-side clock supervision: watches the terminal-supplied card clock
 * for range, duty and stop, tracks operating and idle state, answers the
 * legacy power-down command, checks the terminal's stop and restart
 * waits and sets the bit period for the character layer.
 * assumes the character layer reports commands and response ends, and
 * that all terminal pins are synchronous to core_clk.
 */
`timescale 1ns/1ps
module ccsb_card_clk_ctrl (
	// clock, reset, enable
	input wire logic core_clk,
	input wire logic resetn,
	input wire logic clk_en,
	// terminal pins
	input wire logic card_clk_in,
	input wire logic card_rst_n_in,
	// card configuration
	input wire logic cfg_stop_allowed,
	input wire logic cfg_needs_fast_clk,
	// character layer
	input wire logic cmd_valid,
	input wire logic [7:0] cmd_ins,
	input wire logic cmd_done,
	input wire logic xfer_active,
	input wire logic resp_done,
	input wire logic start_bit,
	// rate exchange result
	input wire logic rate_ok,
	input wire logic [ccsb_pkg::DIV_W-1:0] rate_divisor,
	// status word answer
	output logic sw_valid,
	output logic [7:0] first_status_byte,
	output logic [7:0] second_status_byte,
	// bit timing
	output logic etu_tick,
	output logic half_tick,
	output logic [ccsb_pkg::DIV_W-1:0] bit_period,
	// state and supervision
	output logic [7:0] file_char_byte1,
	output logic operating,
	output logic clk_stopped,
	output logic freq_err,
	output logic duty_err,
	output logic stop_early_err,
	output logic start_early_err,
	output logic stop_denied_err
);
	ccsb_pkg::ccsb_state_t st_r; // activity state
	ccsb_pkg::ccsb_state_t st_nxt;
	logic clk_d_r; // last card clock sample
	logic seen_r; // at least one rise since stop or reset
	logic [ccsb_pkg::PER_W-1:0] per_cnt_r; // core cycles since last rise
	logic [ccsb_pkg::PER_W-1:0] hi_len_r; // high time of last period
	logic stopped_r;
	logic [ccsb_pkg::CYC_W-1:0] stop_cnt_r; // card cycles since response
	logic [ccsb_pkg::CYC_W-1:0] start_cnt_r; // card cycles since restart
	logic [ccsb_pkg::CYC_W-1:0] stop_need_r; // required wait before stop
	logic stop_armed_r; // a response ended and the stop wait runs
	logic start_armed_r; // a restart happened and the start wait runs
	logic pd_seen_r; // a power-down answer went out since the last response or command header
	logic [ccsb_pkg::DIV_W-1:0] div_r;
	logic sw_valid_r;
	logic [7:0] sw1_r;
	logic [7:0] sw2_r;
	logic [7:0] fc_r;
	logic freq_err_r;
	logic duty_err_r;
	logic stop_early_r;
	logic start_early_r;
	logic stop_denied_r;

	// saturating increment used by both cycle counters
	function automatic logic [ccsb_pkg::CYC_W-1:0] sat_inc(
		input logic [ccsb_pkg::CYC_W-1:0] v);
		sat_inc = (&v) ? v : v + 11'h001;
	endfunction : sat_inc

	// edge and period decode
	wire card_rise = card_clk_in & ~clk_d_r;
	wire card_fall = ~card_clk_in & clk_d_r;
	wire [ccsb_pkg::PER_W-1:0] period = per_cnt_r + 8'h01;
	wire stop_det = (per_cnt_r ==
		ccsb_pkg::PER_W'(ccsb_pkg::STOP_DET_CYC - 1));
	wire restart = card_rise & stopped_r;
	wire card_reset = ~card_rst_n_in;
	// headers come from the half-duplex character layer
	wire is_power_down = cmd_valid &
		(cmd_ins == ccsb_pkg::INS_POWER_DOWN);
	// longest period depends on whether the card asked for a fast clock
	wire [ccsb_pkg::PER_W-1:0] per_max = cfg_needs_fast_clk ?
		ccsb_pkg::PER_W'(ccsb_pkg::PER_FAST_MAX_CYC) :
		ccsb_pkg::PER_W'(ccsb_pkg::PER_SLOW_MAX_CYC);
	wire per_bad = (period < ccsb_pkg::PER_W'(ccsb_pkg::PER_MIN_CYC)) |
		(period > per_max);
	// duty check in fifths keeps it to shifts and adds
	wire [10:0] hi_x5 = {3'h0, hi_len_r} * 11'd5;
	wire [10:0] per_lo = {3'h0, period} *
		11'(ccsb_pkg::DUTY_LO_FIFTHS);
	wire [10:0] per_hi = {3'h0, period} *
		11'(ccsb_pkg::DUTY_HI_FIFTHS);
	wire duty_bad = (hi_x5 < per_lo) | (hi_x5 > per_hi);
	// checks only mean something on a full period after a running start
	wire check_now = card_rise & seen_r & ~stopped_r;
	// stopping early or while not allowed
	wire stop_early = stop_det & stop_armed_r &
		(stop_cnt_r < stop_need_r);
	wire stop_denied = stop_det & ~stopped_r & seen_r &
		~cfg_stop_allowed;
	wire start_early = cmd_valid & start_armed_r &
		(start_cnt_r < ccsb_pkg::START_WAIT_CYC);

	assign sw_valid = sw_valid_r;
	assign first_status_byte = sw1_r;
	assign second_status_byte = sw2_r;
	assign bit_period = div_r;
	assign file_char_byte1 = fc_r;
	assign operating = (st_r != ccsb_pkg::CCSB_IDLE);
	assign clk_stopped = stopped_r;
	assign freq_err = freq_err_r;
	assign duty_err = duty_err_r;
	assign stop_early_err = stop_early_r;
	assign start_early_err = start_early_r;
	assign stop_denied_err = stop_denied_r;

	// activity state; registers are never cleared on idle so data is kept
	always_comb begin
		st_nxt = st_r;
		case (st_r)
			ccsb_pkg::CCSB_IDLE: begin
				if (is_power_down) begin
					st_nxt = ccsb_pkg::CCSB_ANSWER;
				end else if (cmd_valid | xfer_active) begin
					st_nxt = ccsb_pkg::CCSB_OPERATING;
				end
			end
			ccsb_pkg::CCSB_OPERATING: begin
				if (cmd_done & ~xfer_active) begin
					st_nxt = ccsb_pkg::CCSB_IDLE;
				end
			end
			ccsb_pkg::CCSB_ANSWER: begin
				// one cycle to present the status words
				st_nxt = ccsb_pkg::CCSB_OPERATING;
			end
			default: begin
				st_nxt = ccsb_pkg::CCSB_IDLE;
			end
		endcase
	end

	// state register and card clock sampling; the pin sample ignores the
	// card reset, otherwise a high clock pin would look like a fresh rise
	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			st_r <= ccsb_pkg::CCSB_IDLE;
			clk_d_r <= 1'b0;
		end else if (clk_en) begin
			st_r <= card_reset ? ccsb_pkg::CCSB_IDLE : st_nxt;
			clk_d_r <= card_clk_in;
		end
	end

	// period, high time and stop detection in core cycles
	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			per_cnt_r <= '0;
			hi_len_r <= '0;
			stopped_r <= 1'b1;
			seen_r <= 1'b0;
		end else if (clk_en) begin
			if (card_rise) begin
				per_cnt_r <= '0;
				stopped_r <= 1'b0;
				seen_r <= 1'b1;
			end else if (stop_det) begin
				stopped_r <= 1'b1;
				seen_r <= 1'b0;
			end else begin
				per_cnt_r <= period;
			end
			if (card_fall) begin
				hi_len_r <= period;
			end
		end
	end

	// wait counters in card cycles, so the checks track the card clock
	always_ff @(posedge core_clk) begin
		if (!resetn || card_reset) begin
			stop_cnt_r <= '0;
			start_cnt_r <= '0;
			stop_need_r <= ccsb_pkg::STOP_WAIT_CYC;
			stop_armed_r <= 1'b0;
			start_armed_r <= 1'b0;
			pd_seen_r <= 1'b0;
		end else if (clk_en) begin
			// remember the power-down answer until its response ends or a command header comes
			if (st_r == ccsb_pkg::CCSB_ANSWER) begin
				pd_seen_r <= 1'b1;
			end else if (resp_done | cmd_valid) begin
				pd_seen_r <= 1'b0;
			end
			if (resp_done) begin
				// a power-down answer only needs the shorter wait
				stop_cnt_r <= '0;
				stop_armed_r <= 1'b1;
				stop_need_r <= pd_seen_r ?
					ccsb_pkg::SLEEP_WAIT_CYC :
					ccsb_pkg::STOP_WAIT_CYC;
			end else if (cmd_valid | stop_det) begin
				stop_armed_r <= 1'b0;
			end else if (card_rise) begin
				stop_cnt_r <= sat_inc(stop_cnt_r);
			end
			if (restart) begin
				start_cnt_r <= '0;
				start_armed_r <= 1'b1;
			end else if (cmd_valid) begin
				start_armed_r <= 1'b0;
			end else if (card_rise) begin
				start_cnt_r <= sat_inc(start_cnt_r);
			end
		end
	end

	// bit period: default after card reset, negotiated after exchange
	always_ff @(posedge core_clk) begin
		if (!resetn || card_reset) begin
			div_r <= ccsb_pkg::ETU_DEFAULT;
		end else if (clk_en && rate_ok && rate_divisor != '0) begin
			div_r <= rate_divisor;
		end
	end

	// status word answer for the legacy power-down command
	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			sw_valid_r <= 1'b0;
			sw1_r <= 8'h00;
			sw2_r <= 8'h00;
		end else if (clk_en) begin
			sw_valid_r <= (st_r == ccsb_pkg::CCSB_ANSWER);
			if (st_r == ccsb_pkg::CCSB_ANSWER) begin
				sw1_r <= ccsb_pkg::SW_NORMAL_1;
				sw2_r <= ccsb_pkg::SW_NORMAL_2;
			end
		end
	end

	// file characteristics byte 1 mirrors the card configuration
	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			fc_r <= ccsb_pkg::FC_RESET;
		end else if (clk_en) begin
			fc_r <= ccsb_pkg::FC_RESET;
			fc_r[ccsb_pkg::FC_STOP_OK_BIT] <= cfg_stop_allowed;
			fc_r[ccsb_pkg::FC_FAST_CLK_BIT] <= cfg_needs_fast_clk;
		end
	end

	// sticky error flags; a set in the clearing cycle wins
	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			freq_err_r <= 1'b0;
			duty_err_r <= 1'b0;
			stop_early_r <= 1'b0;
			start_early_r <= 1'b0;
			stop_denied_r <= 1'b0;
		end else if (clk_en) begin
			if (check_now & per_bad) begin
				freq_err_r <= 1'b1;
			end else if (card_reset) begin
				freq_err_r <= 1'b0;
			end
			if (check_now & duty_bad) begin
				duty_err_r <= 1'b1;
			end else if (card_reset) begin
				duty_err_r <= 1'b0;
			end
			if (stop_early) begin
				stop_early_r <= 1'b1;
			end else if (card_reset) begin
				stop_early_r <= 1'b0;
			end
			if (start_early) begin
				start_early_r <= 1'b1;
			end else if (card_reset) begin
				start_early_r <= 1'b0;
			end
			if (stop_denied) begin
				stop_denied_r <= 1'b1;
			end else if (card_reset) begin
				stop_denied_r <= 1'b0;
			end
		end
	end

	// bit timer runs from card clock edges, restarted on each start bit
	ccsb_etu_timer u_etu (
		.core_clk(core_clk),
		.resetn(resetn),
		.clk_en(clk_en),
		.card_rise(card_rise),
		.restart(start_bit | card_reset),
		.divisor(div_r),
		.etu_tick(etu_tick),
		.half_tick(half_tick)
	);
endmodule : ccsb_card_clk_ctrl

// ---- dv/ccsb_term_model.sv ----
/*
 * terminal-side card clock source for the clock supervision bench.
 * assumes the bench sets period and high time in core cycles.
 */
`timescale 1ns/1ps
module ccsb_term_model (
	// core clock
	core_clk,
	// clock shape from the bench
	run,
	per,
	hi,
	// card clock pin
	card_clk
);
	input wire logic core_clk;
	input wire logic run;
	input wire logic [7:0] per;
	input wire logic [7:0] hi;
	output logic card_clk;
	logic [7:0] cnt_r; // position inside the current period

	// counts on the rising edge, so the pin moves on the same edge on which the design samples it
	always_ff @(posedge core_clk) begin
		cnt_r <= (!run || cnt_r >= per - 8'h01) ? 8'h00 : cnt_r + 8'h01;
	end

	// stopped clock rests low between bursts, never left floating
	assign card_clk = run && (cnt_r < hi);
endmodule : ccsb_term_model

// ---- dv/ccsb_card_clk_ctrl_properties.sv ----
/*
 * concurrent checks on the ports of the card clock supervision block.
 * assumes one core clock domain and the synchronous resetn.
 */
`timescale 1ns/1ps
module ccsb_clk_props (
	// clock and reset
	input wire logic core_clk,
	input wire logic resetn,
	input wire logic clk_en,
	// inputs that cause outputs
	input wire logic card_rst_n_in,
	input wire logic cfg_stop_allowed,
	input wire logic cfg_needs_fast_clk,
	input wire logic cmd_valid,
	input wire logic [7:0] cmd_ins,
	input wire logic rate_ok,
	input wire logic [11:0] rate_divisor,
	// watched outputs
	input wire logic sw_valid,
	input wire logic [7:0] first_status_byte,
	input wire logic [7:0] second_status_byte,
	input wire logic [11:0] bit_period,
	input wire logic [7:0] file_char_byte1,
	input wire logic operating,
	input wire logic clk_stopped,
	input wire logic stop_denied_err
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!resetn);

	// power-down taken while idle
	sequence s_pd_req;
		clk_en && cmd_valid && !operating && cmd_ins == 8'hf0;
	endsequence
	// answer lands exactly two edges later
	sequence s_pd_ans;
		!sw_valid ##1 sw_valid && first_status_byte == 8'h90 &&
			second_status_byte == 8'h00;
	endsequence

	a_pd_answer: assert property (s_pd_req |=> s_pd_ans)
		else $error("power-down answer wrong");
	a_sw_single: assert property (sw_valid |=> !sw_valid)
		else $error("status valid longer than one cycle");
	a_period_reset: assert property ($rose(resetn) |-> bit_period == 12'h174)
		else $error("bit period not default after reset");
	a_rate_load: assert property (rate_ok && rate_divisor != 12'h000 &&
		card_rst_n_in && clk_en |=> bit_period == $past(rate_divisor))
		else $error("negotiated period not loaded");
	a_period_hold: assert property (!$stable(bit_period) |->
		$past(rate_ok) || !$past(card_rst_n_in))
		else $error("bit period changed without cause");
	a_op_cause: assert property ($rose(operating) |-> $past(cmd_valid))
		else $error("operating without command");
	a_fast_flag: assert property (clk_en |=>
		file_char_byte1[2] == $past(cfg_needs_fast_clk))
		else $error("fast clock flag wrong");
	a_denied_flag: assert property ($rose(clk_stopped) &&
		!cfg_stop_allowed |-> ##[0:2] stop_denied_err)
		else $error("forbidden stop not flagged");
	a_denied_sticky: assert property (stop_denied_err &&
		card_rst_n_in |=> stop_denied_err)
		else $error("stop flag lost");
endmodule : ccsb_clk_props

bind ccsb_card_clk_ctrl ccsb_clk_props u_props (.core_clk, .resetn,
	.clk_en, .card_rst_n_in, .cfg_stop_allowed, .cfg_needs_fast_clk,
	.cmd_valid, .cmd_ins, .rate_ok, .rate_divisor, .sw_valid,
	.first_status_byte, .second_status_byte, .bit_period,
	.file_char_byte1, .operating, .clk_stopped, .stop_denied_err);

// ---- dv/tb.sv ----
/*
 * self-checking bench for the card clock supervision block.
 * assumes the terminal model supplies the card clock pin.
 */
`timescale 1ns/1ps
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin errors++; \
	$display("[FAIL] %s exp %0h got %0h", nm, e, g); end end
module tb;
	logic core_clk, resetn, clk_en, card_clk_in, card_rst_n_in;
	logic cfg_stop_allowed, cfg_needs_fast_clk, cmd_valid, cmd_done;
	logic xfer_active, resp_done, start_bit, rate_ok, run;
	logic sw_valid, etu_tick, half_tick, operating, clk_stopped, freq_err;
	logic duty_err, stop_early_err, start_early_err, stop_denied_err;
	logic [7:0] cmd_ins, per, hi, first_status_byte, second_status_byte;
	logic [7:0] file_char_byte1;
	logic [11:0] rate_divisor, bit_period;
	int errors, num_checks, g;

	// design under test, every port matched by name
	ccsb_card_clk_ctrl u_ccsb_card_clk_ctrl (.*);
	// terminal model drives the card clock pin
	ccsb_term_model u_ccsb_term_model (.core_clk(core_clk), .run(run),
		.per(per), .hi(hi), .card_clk(card_clk_in));

	// 50 MHz core clock
	initial begin
		core_clk = 1'b0;
		forever #10 core_clk = ~core_clk;
	end

	task cyc(input int k);
		repeat (k) @(negedge core_clk);
	endtask : cyc

	task give_verdict;
		$display("checks %0d errors %0d", num_checks, errors);
		if (errors == 0 && num_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : give_verdict

	// card reset pin pulse clears flags and the period
	task crst;
		card_rst_n_in = 1'b0;
		cyc(1);
		card_rst_n_in = 1'b1;
		cyc(1);
	endtask : crst

	// core cycles between two bit ticks; a lost tick ends the run
	task tick_gap(output int n);
		int i;
		i = 0;
		n = 1;
		while (etu_tick !== 1'b1 && i < 9000) begin
			i++;
			cyc(1);
		end
		cyc(1);
		while (etu_tick !== 1'b1 && n < 9000) begin
			n++;
			cyc(1);
		end
		if (i >= 9000 || n >= 9000) begin
			errors++;
			give_verdict;
		end
	endtask : tick_gap

	// one command header; the answer, if any, is seen two edges on
	task cmd(input logic [7:0] ins, input logic exp_sw);
		cmd_ins = ins;
		cmd_valid = 1'b1;
		cyc(1);
		cmd_valid = 1'b0;
		cyc(1);
		`CHK("sw_valid", exp_sw, sw_valid)
	endtask : cmd

	task done;
		cmd_done = 1'b1;
		cyc(1);
		cmd_done = 1'b0;
		cyc(1);
		`CHK("operating", 1'b0, operating)
	endtask : done

	// set a clock shape, clear flags after the change, then judge it
	task clk_set(input logic [7:0] p, h, input logic ef, ed);
		per = p;
		hi = h;
		cyc(40);
		crst;
		cyc(200);
		`CHK("freq_err", ef, freq_err)
		`CHK("duty_err", ed, duty_err)
	endtask : clk_set

	task t_rate;
		run = 1'b1;
		start_bit = 1'b1;
		cyc(1);
		start_bit = 1'b0;
		tick_gap(g);
		`CHK("gap372", 3720, g)
		per = 8'h14;
		hi = 8'h0a;
		tick_gap(g);
		`CHK("gap_slow", 7440, g)
		rate_divisor = 12'h01f;
		rate_ok = 1'b1;
		cyc(1);
		rate_divisor = 12'h000;
		rate_ok = 1'b0;
		cyc(1);
		`CHK("bit_period", 12'h01f, bit_period)
		start_bit = 1'b1;
		cyc(1);
		start_bit = 1'b0;
		tick_gap(g);
		`CHK("gap_rate", 620, g)
		crst;
		`CHK("bit_period", 12'h174, bit_period)
		$display("t_rate done");
	endtask : t_rate

	// the bench plays an older terminal; a newer one never sends f0
	task t_pd;
		cmd(8'ha4, 1'b0);
		`CHK("operating", 1'b1, operating)
		cmd(8'hf0, 1'b0);
		done;
		cmd(8'hf0, 1'b1);
		`CHK("sw1", 8'h90, first_status_byte)
		`CHK("sw2", 8'h00, second_status_byte)
		done;
		$display("t_pd done");
	endtask : t_pd

	task t_stop;
		per = 8'h0a;
		hi = 8'h05;
		resp_done = 1'b1;
		cyc(1);
		resp_done = 1'b0;
		cyc(18800);
		run = 1'b0;
		cyc(110);
		`CHK("clk_stopped", 1'b1, clk_stopped)
		`CHK("stop_early", 1'b0, stop_early_err)
		run = 1'b1;
		cyc(7500);
		cmd(8'ha4, 1'b0);
		`CHK("start_early", 1'b0, start_early_err)
		done;
		resp_done = 1'b1;
		cyc(1);
		resp_done = 1'b0;
		cyc(20);
		run = 1'b0;
		cyc(110);
		`CHK("stop_early", 1'b1, stop_early_err)
		run = 1'b1;
		cyc(50);
		cmd(8'ha4, 1'b0);
		`CHK("start_early", 1'b1, start_early_err)
		done;
		crst;
		cfg_stop_allowed = 1'b0;
		run = 1'b0;
		cyc(110);
		`CHK("stop_denied", 1'b1, stop_denied_err)
		run = 1'b1;
		cfg_stop_allowed = 1'b1;
		$display("t_stop done");
	endtask : t_stop

	// after a power-down answer the shorter stop wait is enough
	task t_sleep;
		crst;
		cmd(8'hf0, 1'b1);
		done;
		resp_done = 1'b1;
		cyc(1);
		resp_done = 1'b0;
		cyc(7500);
		run = 1'b0;
		cyc(110);
		`CHK("clk_stopped", 1'b1, clk_stopped)
		`CHK("stop_early", 1'b0, stop_early_err)
		run = 1'b1;
		cyc(20);
		$display("t_sleep done");
	endtask : t_sleep

	task t_clk;
		per = 8'h0a;
		clk_set(8'h0a, 8'h04, 1'b0, 1'b0);
		clk_set(8'h0a, 8'h03, 1'b0, 1'b1);
		clk_set(8'h1e, 8'h0f, 1'b0, 1'b0);
		clk_set(8'h1f, 8'h0f, 1'b1, 1'b0);
		cfg_needs_fast_clk = 1'b1;
		clk_set(8'h0f, 8'h07, 1'b0, 1'b0);
		clk_set(8'h10, 8'h08, 1'b1, 1'b0);
		`CHK("fc_fast", 1'b1, file_char_byte1[2])
		$display("t_clk done");
	endtask : t_clk

	// main sequence: reset, then each scenario in turn
	initial begin
		errors = 0;
		num_checks = 0;
		{resetn, cmd_valid, cmd_done, xfer_active, resp_done} = 5'h00;
		{start_bit, rate_ok, run, cfg_needs_fast_clk} = 4'h0;
		{clk_en, card_rst_n_in, cfg_stop_allowed} = 3'h7;
		cmd_ins = 8'h00;
		rate_divisor = 12'h000;
		per = 8'h0a;
		hi = 8'h05;
		cyc(16);
		resetn = 1'b1;
		cyc(1);
		`CHK("bit_period", 12'h174, bit_period)
		`CHK("operating", 1'b0, operating)
		t_rate;
		t_pd;
		t_stop;
		t_sleep;
		t_clk;
		give_verdict;
	end
endmodule : tb
